// ### design/option_map.vh
// register offsets, field positions, reset values and codes for option decoding
`ifndef OPTION_MAP_VH
`define OPTION_MAP_VH
`define OFS_READOUT_LOCK     8'h00
`define OFS_BOOT_AREA        8'h04
`define OFS_SPARE_OPTION     8'h08
`define OFS_WATCHDOG_OPTION  8'h0C
`define OFS_OSC_SETTLE       8'h10
`define OFS_DECODED_STATUS   8'h14
`define OFS_APPLY_CTRL       8'h18
`define RST_READOUT_LOCK     8'h00
`define RST_BOOT_AREA        8'h00
`define RST_SPARE_OPTION     8'h00
`define RST_WATCHDOG_OPTION  8'h00
`define RST_OSC_SETTLE       8'h00
`define READOUT_UNLOCK_CODE  8'hAA
`define BOOT_NONE            8'h00
`define BOOT_VECTORS_ONLY    8'h01
`define BOOT_TWO_PAGES       8'h02
`define BIT_INDEP_HW_START   0
`define BIT_INDEP_HALT_STOP  1
`define BIT_WIN_HW_START     2
`define BIT_WIN_HALT_RESET   3
`define FAST_SETTLE_LSB      0
`define SLOW_SETTLE_LSB      2
`define SETTLE_CYCLES_0      13'h0001
`define SETTLE_CYCLES_1      13'h0010
`define SETTLE_CYCLES_2      13'h0200
`define SETTLE_CYCLES_3      13'h1000
`endif

// ### design/settle_count_decoder.v
// maps a two-bit settle count code to an oscillator cycle count
`timescale 1ns/1ps
module settle_count_decoder
(
	// code in
	input  wire [1:0]  code,
	// cycles out
	output reg  [12:0] cycles
);
`include "option_map.vh"
// codes read as binary 00, 01, 10, 11
always @*
begin
	case (code)
		2'h0: cycles = `SETTLE_CYCLES_0;
		2'h1: cycles = `SETTLE_CYCLES_1;
		2'h2: cycles = `SETTLE_CYCLES_2;
		2'h3: cycles = `SETTLE_CYCLES_3;
		default: cycles = `SETTLE_CYCLES_0;
	endcase
end
endmodule

// ### design/boot_area_decoder.v
// decodes the boot area size into page range and protection kind
`timescale 1ns/1ps
module boot_area_decoder
(
	// size code in
	input  wire [7:0] size,
	// decoded outputs
	output reg        present,
	output reg        vectors_only,
	output reg  [7:0] last_page,
	output reg        read_protect,
	output reg        write_protect
);
`include "option_map.vh"
always @*
begin
	present       = 1'b1;
	vectors_only  = 1'b0;
	last_page     = 8'h00;
	read_protect  = 1'b0;
	write_protect = 1'b0;
	// RULE3 no boot area
	if (size == `BOOT_NONE)
	begin
		present = 1'b0;
	end
	// RULE4 vectors only
	else if (size == `BOOT_VECTORS_ONLY)
	begin
		vectors_only = 1'b1;
	end
	// RULE5 two pages, read/write locked
	else if (size == `BOOT_TWO_PAGES)
	begin
		last_page     = 8'h01;
		read_protect  = 1'b1;
		write_protect = 1'b1;
	end
	// RULE6 pages zero to size minus one
	else
	begin
		last_page     = size - 8'h01;
		write_protect = 1'b1;
	end
end
endmodule

// ### design/option_byte_decoder.v
// option byte registers on ahb-lite and the decoded configuration controls
//
// Behaviour
// RULE1: readout lock byte equal to 0xAA leaves readout protection off.
// RULE2: any other readout lock byte value turns readout protection on.
// RULE3: boot area size zero means no boot area, nothing reserved.
// RULE4: boot area size one means boot area holds only vectors.
// RULE5: size two reserves pages zero and one, read and write protected.
// RULE6: size three up reserves pages 0 to size minus one, write protected.
// RULE7: independent watchdog hw-start bit set starts it by hardware.
// RULE8: independent watchdog halt-stop bit set stops it in halt modes.
// RULE9: window watchdog hw-start bit set starts it by hardware.
// RULE10: window watchdog halt-reset bit set resets on halt entry, else stops.
// RULE11: fast oscillator settle code picks 1, 16, 512 or 4096 cycles.
// RULE12: slow oscillator settle code picks 1, 16, 512 or 4096 cycles.
// RULE13: settle codes are two-bit binary fields 00, 01, 10, 11.
`timescale 1ns/1ps
module option_byte_decoder
(
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// readout protection
	output reg         readout_protect,
	// boot area
	output reg         boot_present,
	output reg         boot_vectors_only,
	output reg  [7:0]  boot_last_page,
	output reg         boot_read_protect,
	output reg         boot_write_protect,
	// watchdogs
	output reg         indep_dog_hw_start,
	output reg         indep_dog_halt_stop,
	output reg         win_dog_hw_start,
	output reg         win_dog_halt_reset,
	// oscillator settle counts
	output reg  [12:0] fast_osc_settle_cycles,
	output reg  [12:0] slow_osc_settle_cycles
);
`include "option_map.vh"
////////////////////////////////////////////////////////////////////////////
reg  [7:0]  readout_lock_byte_q;
reg  [7:0]  boot_area_size_byte_q;
reg  [7:0]  spare_option_byte_q;
reg  [7:0]  watchdog_option_byte_q;
reg  [7:0]  oscillator_settle_byte_q;
reg         apply_q;
reg         wr_pend_q;
reg  [7:0]  wr_addr_q;
wire        take;
wire        dec_present;
wire        dec_vectors;
wire [7:0]  dec_last;
wire        dec_rprot;
wire        dec_wprot;
wire [12:0] fast_cycles;
wire [12:0] slow_cycles;
// zero wait states, always okay
assign hreadyout = 1'b1;
assign hresp     = 1'b0;
assign take      = hsel & hready & htrans[1];
////////////////////////////////////////////////////////////////////////////
// address phase capture and write data phase
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		wr_pend_q <= 1'b0;
		wr_addr_q <= 8'h00;
	end
	else if (hready)
	begin
		wr_pend_q <= take & hwrite;
		wr_addr_q <= haddr;
	end
end
// apply pulse follows any write so new options take effect next cycle
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		readout_lock_byte_q      <= `RST_READOUT_LOCK;
		boot_area_size_byte_q    <= `RST_BOOT_AREA;
		spare_option_byte_q      <= `RST_SPARE_OPTION;
		watchdog_option_byte_q   <= `RST_WATCHDOG_OPTION;
		oscillator_settle_byte_q <= `RST_OSC_SETTLE;
		apply_q                  <= 1'b1;
	end
	else
	begin
		apply_q <= wr_pend_q;
		if (wr_pend_q)
		begin
			case (wr_addr_q)
				`OFS_READOUT_LOCK:    readout_lock_byte_q <= hwdata[7:0];
				`OFS_BOOT_AREA:       boot_area_size_byte_q <= hwdata[7:0];
				`OFS_WATCHDOG_OPTION: watchdog_option_byte_q <= hwdata[7:0];
				`OFS_OSC_SETTLE:   oscillator_settle_byte_q <= hwdata[7:0];
				default:              spare_option_byte_q <= spare_option_byte_q;
			endcase
		end
	end
end
////////////////////////////////////////////////////////////////////////////
// decoders
boot_area_decoder u_boot
(
	.size          (boot_area_size_byte_q),
	.present       (dec_present),
	.vectors_only  (dec_vectors),
	.last_page     (dec_last),
	.read_protect  (dec_rprot),
	.write_protect (dec_wprot)
);
// RULE11 fast settle lookup
settle_count_decoder u_fast
(
	.code   (oscillator_settle_byte_q[`FAST_SETTLE_LSB+1:`FAST_SETTLE_LSB]),
	.cycles (fast_cycles)
);
// RULE12 slow settle lookup
settle_count_decoder u_slow
(
	.code   (oscillator_settle_byte_q[`SLOW_SETTLE_LSB+1:`SLOW_SETTLE_LSB]),
	.cycles (slow_cycles)
);
////////////////////////////////////////////////////////////////////////////
// outputs registered; reset state is the safe, protected one
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		readout_protect        <= 1'b1;
		boot_present           <= 1'b0;
		boot_vectors_only      <= 1'b0;
		boot_last_page         <= 8'h00;
		boot_read_protect      <= 1'b0;
		boot_write_protect     <= 1'b0;
		indep_dog_hw_start     <= 1'b0;
		indep_dog_halt_stop    <= 1'b0;
		win_dog_hw_start       <= 1'b0;
		win_dog_halt_reset     <= 1'b0;
		fast_osc_settle_cycles <= `SETTLE_CYCLES_0;
		slow_osc_settle_cycles <= `SETTLE_CYCLES_0;
	end
	else if (apply_q)
	begin
		// RULE1 RULE2 unlock only on code
		readout_protect <= (readout_lock_byte_q != `READOUT_UNLOCK_CODE);
		// RULE3 RULE4 RULE5 RULE6 boot area
		boot_present       <= dec_present;
		boot_vectors_only  <= dec_vectors;
		boot_last_page     <= dec_last;
		boot_read_protect  <= dec_rprot;
		boot_write_protect <= dec_wprot;
		// RULE7 independent hw start
		indep_dog_hw_start <=
			watchdog_option_byte_q[`BIT_INDEP_HW_START];
		// RULE8 independent halt stop
		indep_dog_halt_stop <=
			watchdog_option_byte_q[`BIT_INDEP_HALT_STOP];
		// RULE9 window hw start
		win_dog_hw_start <= watchdog_option_byte_q[`BIT_WIN_HW_START];
		// RULE10 window halt reset
		win_dog_halt_reset <=
			watchdog_option_byte_q[`BIT_WIN_HALT_RESET];
		// RULE13 two-bit codes
		fast_osc_settle_cycles <= fast_cycles;
		slow_osc_settle_cycles <= slow_cycles;
	end
end
////////////////////////////////////////////////////////////////////////////
// read data; decoded status word shows live controls
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
		hrdata <= 32'h00000000;
	else if (take & ~hwrite)
	begin
		case (haddr)
			`OFS_READOUT_LOCK:    hrdata <= {24'h000000, readout_lock_byte_q};
			`OFS_BOOT_AREA:       hrdata <= {24'h000000, boot_area_size_byte_q};
			`OFS_SPARE_OPTION:    hrdata <= {24'h000000, spare_option_byte_q};
			`OFS_WATCHDOG_OPTION: hrdata <= {24'h000000, watchdog_option_byte_q};
			`OFS_OSC_SETTLE:    hrdata <= {24'h000000, oscillator_settle_byte_q};
			`OFS_DECODED_STATUS:
				hrdata <= {16'h0000, boot_last_page, win_dog_halt_reset,
					win_dog_hw_start, indep_dog_halt_stop,
					indep_dog_hw_start, boot_write_protect,
					boot_read_protect, boot_present, readout_protect};
			default:              hrdata <= 32'h00000000;
		endcase
	end
end
endmodule

// ### test/option_byte_decoder_asserts.sv
// port checks for the option byte decoder
`timescale 1ns/1ps
module option_byte_decoder_asserts
(
	// bus side
	input logic        hclk,
	input logic        hresetn,
	input logic        hsel,
	input logic [7:0]  haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic        hready,
	// decoded side
	input logic        readout_protect,
	input logic        boot_present,
	input logic        boot_vectors_only,
	input logic [7:0]  boot_last_page,
	input logic        boot_read_protect,
	input logic        boot_write_protect,
	input logic        indep_dog_hw_start,
	input logic        indep_dog_halt_stop,
	input logic        win_dog_hw_start,
	input logic        win_dog_halt_reset,
	input logic [12:0] fast_osc_settle_cycles,
	input logic [12:0] slow_osc_settle_cycles
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// write taken in an address phase
	wire       wgo = hsel && hready && htrans[1] && hwrite;
	wire [3:0] dog = {win_dog_halt_reset, win_dog_hw_start,
		indep_dog_halt_stop, indep_dog_hw_start};
	// stored at the data-phase edge, applied next, seen one sample later
	property p_rop;
		$changed(readout_protect) |-> $past(wgo && haddr == 8'h00, 3);
	endproperty
	a_rop: assert property (p_rop)
		else $error("lock moved without write");
	property p_none;
		!boot_present |->
			!boot_vectors_only && !boot_read_protect && !boot_write_protect;
	endproperty
	a_none: assert property (p_none)
		else $error("flags without area");
	property p_vec;
		boot_vectors_only |->
			boot_present && boot_last_page == 8'h00 && !boot_write_protect;
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector area wrong");
	property p_two;
		boot_read_protect |-> boot_write_protect && boot_last_page == 8'h01;
	endproperty
	a_two: assert property (p_two)
		else $error("two page area wrong");
	property p_wp;
		boot_write_protect && !boot_read_protect |-> boot_last_page >= 8'h02;
	endproperty
	a_wp: assert property (p_wp)
		else $error("write area too small");
	property p_boot;
		$changed(boot_last_page) |-> $past(wgo && haddr == 8'h04, 3);
	endproperty
	a_boot: assert property (p_boot)
		else $error("area moved without write");
	property p_dog;
		$changed(dog) |-> $past(wgo && haddr == 8'h0C, 3);
	endproperty
	a_dog: assert property (p_dog)
		else $error("dog moved without write");
	property p_osc;
		$changed({fast_osc_settle_cycles, slow_osc_settle_cycles}) |->
			$past(wgo && haddr == 8'h10, 3);
	endproperty
	a_osc: assert property (p_osc)
		else $error("count moved without write");
	// legal counts use only bits 12, 9, 4 and 0
	property p_fast;
		$onehot(fast_osc_settle_cycles) &&
			(fast_osc_settle_cycles & 13'h0DEE) == 13'h0000;
	endproperty
	a_fast: assert property (p_fast)
		else $error("fast count illegal");
	property p_slow;
		$onehot(slow_osc_settle_cycles) &&
			(slow_osc_settle_cycles & 13'h0DEE) == 13'h0000;
	endproperty
	a_slow: assert property (p_slow)
		else $error("slow count illegal");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind option_byte_decoder option_byte_decoder_asserts option_byte_decoder_asserts_inst
(
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .readout_protect,
	.boot_present, .boot_vectors_only, .boot_last_page, .boot_read_protect,
	.boot_write_protect, .indep_dog_hw_start, .indep_dog_halt_stop,
	.win_dog_hw_start, .win_dog_halt_reset, .fast_osc_settle_cycles,
	.slow_osc_settle_cycles
);

// ### test/option_byte_decoder_bench.sv
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
module option_byte_decoder_bench;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, rp;
	wire  [3:0]  bf, dog;
	wire  [7:0]  blp;
	wire  [12:0] fc, sc;
	int          n_errors = 0;
	int          checks = 0;
	always #10 hclk = ~hclk;
	// hready loops back from the one slave
	option_byte_decoder option_byte_decoder_inst
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .readout_protect(rp), .boot_present(bf[3]),
		.boot_vectors_only(bf[2]), .boot_last_page(blp),
		.boot_read_protect(bf[1]), .boot_write_protect(bf[0]),
		.indep_dog_hw_start(dog[0]), .indep_dog_halt_stop(dog[1]),
		.win_dog_hw_start(dog[2]), .win_dog_halt_reset(dog[3]),
		.fast_osc_settle_cycles(fc), .slow_osc_settle_cycles(sc)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	// decoded outputs land one edge after the data phase
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
		@(posedge hclk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		#1;
		chk(rp, 1'b1);
		chk({bf, blp}, 12'h000);
		chk({fc, sc}, {13'h0001, 13'h0001});
		$display("reset test done");
	endtask
	task automatic t_lock;
		wr(8'h00, 32'h0000_00AA);
		chk(rp, 1'b0);
		wr(8'h00, 32'h0000_00AB);
		chk(rp, 1'b1);
		rd(8'h00, 32'h0000_00AB);
		$display("lock test done");
	endtask
	task automatic t_boot;
		logic [7:0] s[5] = '{8'h03, 8'hFF, 8'h02, 8'h01, 8'h00};
		foreach (s[i])
		begin
			wr(8'h04, {24'h0, s[i]});
			chk({bf, blp}, {s[i] != 0, s[i] == 1, s[i] == 2, s[i] >= 2,
				s[i] < 2 ? 8'h00 : s[i] - 8'h01});
			if (s[i] == 8'hFF)
				rd(8'h14, 32'h0000_FE0B);
		end
		$display("boot test done");
	endtask
	task automatic t_dog;
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h0C, 32'h1 << i);
			chk(dog, (32'h1 << i) & 32'hF);
			rd(8'h14, ((32'h1 << i) & 32'hF) << 4 | 32'h1);
		end
		$display("watchdog test done");
	endtask
	task automatic t_osc;
		logic [12:0] c[4] = '{13'h0001, 13'h0010, 13'h0200, 13'h1000};
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h10, 32'(i) | 32'(3 - i) << 2);
			chk({fc, sc}, {c[i], c[3 - i]});
		end
		rd(8'h10, 32'h0000_0003);
		$display("oscillator test done");
	endtask
	// spare and unmapped places never hold data
	task automatic t_refuse;
		wr(8'h08, 32'h0000_00FF);
		rd(8'h08, 32'h0);
		rd(8'h18, 32'h0);
		$display("refuse test done");
	endtask
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset();
		t_lock();
		t_boot();
		t_dog();
		t_osc();
		t_refuse();
		end_sim();
	end
	// whole run needs about 80 cycles
	initial
	begin
		#20000;
		n_errors++;
		end_sim();
	end
endmodule
